// [tb/tb.sv]
// self-checking bench for the window watchdog
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam integer DIV = 4, POR = 20, SHT = 50, OPN = 80, BF = 10, WF = 20;
	localparam integer LEAD = 3922 * DIV, CLS = 800 * DIV, OPW = 840 * DIV, NRS = 157 * DIV;
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, txd = 1'b1, bl = 1'b0, bw = 1'b0, wk = 1'b1;
	logic dbg = 1'b0, uv = 1'b0, rs = 1'b0, ro = 1'b0;
	wire lt, ht, nres, rxd, txo, oe, term;
	wire [1:0] mode;
	int fails = 0, n_tests = 0, n, lows;
	always #20 clk = ~clk;
	wwdg_host host (.clk(clk), .low_trigger_input(lt), .high_trigger_input(ht));
	wwdg_top #(.OSC_DIV(DIV), .POR_CYCLES(POR), .SHORT_CYCLES(SHT), .OPEN_CYCLES(OPN),
		.BUS_FILT(BF), .WAKE_FILT(WF)) dut (.clk(clk), .rst_n(rst_n), .mode_enable(en),
		.txd_in(txd), .bus_low(bl), .bus_weak_low(bw), .wake_pin(wk), .low_trigger_input(lt),
		.high_trigger_input(ht), .debug_mode(dbg), .vcc_undervoltage(uv),
		.timebase_resistor_short(rs), .timebase_resistor_open(ro), .reset_out_n_q(nres),
		.rxd_out_q(rxd), .txd_out_q(txo), .txd_oe_q(oe), .termination_on_q(term), .mode_q(mode));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic rng(input string nm, input int lo, input int hi);
		n_tests++;
		if (n < lo || n > hi) begin
			fails++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask
	task automatic w(input logic v, input int mx);
		n = 0;
		while (nres !== v) begin
			@(negedge clk);
			n++;
			if (n > mx) begin
				fails++;
				$display("[ERR] reset_out expected %0b seen %0b", v, nres);
				finish_test();
			end
		end
	endtask
	task automatic idle(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic quiet(input int k);
		lows = 0;
		repeat (k) begin
			@(negedge clk);
			lows += (nres !== 1'b1);
		end
		chk("reset_low_cycles", 0, lows);
	endtask
	// ------
	// main sequence
	// ------
	initial begin
		void'($urandom(32'h17B9));
		idle(16);
		rst_n = 1'b1;
		w(1, POR + 20);
		rng("por_time", POR - 2, POR + 4);
		chk("mode", 2'h0, mode);
		w(0, LEAD + 40);
		rng("lead_time", LEAD - 12, LEAD + 12);
		w(1, NRS + 40);
		rng("wd_reset_time", NRS - 12, NRS + 12);
		idle($urandom_range(50, 2000));
		host.pulse($urandom_range(0, 1), 100 + $urandom_range(0, 50));
		quiet(CLS + 100);
		host.pulse(1'b0, 100);
		w(0, CLS + OPW + 100);
		rng("open_expiry", CLS + OPW - 40, CLS + OPW - 5);
		w(1, NRS + 40);
		host.pulse(1'b1, 100);
		host.pulse(1'b1, 40);
		host.pulse(1'b0, 40);
		quiet(300);
		host.pulse($urandom_range(0, 1), 100);
		w(0, 4);
		w(1, NRS + 40);
		dbg = 1'b1;
		quiet(LEAD + CLS);
		dbg = 1'b0;
		rst_n = 1'b0;
		idle(3);
		rst_n = 1'b1;
		w(1, POR + 20);
		en = 1'b1;
		idle(4);
		chk("normal", 32'h2, {mode, oe});
		en = 1'b0;
		idle(4);
		chk("silent", 32'h4, {mode, term});
		quiet(LEAD + 100);
		bl = 1'b1;
		idle(BF + 6);
		bl = 1'b0;
		chk("wake", 32'h07, {mode, rxd, txo, oe, term});
		w(0, LEAD + 40);
		rng("wake_lead", LEAD - 16, LEAD + 12);
		w(1, NRS + 40);
		en = 1'b1;
		idle(4);
		chk("cleared", 32'hC, {mode, rxd, txo, oe});
		en = 1'b0;
		idle(4);
		wk = 1'b0;
		idle(WF + 6);
		wk = 1'b1;
		chk("local", 32'h1, {mode, rxd, txo, oe});
		en = 1'b1;
		idle(4);
		en = 1'b0;
		idle(4);
		bw = 1'b1;
		idle(WF + 6);
		bw = 1'b0;
		chk("weak", 32'h1, {mode, rxd, txo, oe});
		en = 1'b1;
		idle(4);
		uv = 1'b1;
		idle(4);
		chk("uv", 32'h0, {nres, mode});
		uv = 1'b0;
		w(1, POR + NRS + 40);
		rs = 1'b1;
		w(0, SHT + 20);
		rng("short_reset", SHT - 4, SHT + 4);
		rs = 1'b0;
		w(1, POR + NRS + 40);
		ro = 1'b1;
		w(0, OPN + 20);
		rng("open_reset", OPN - 4, OPN + 4);
		ro = 1'b0;
		w(1, NRS + 40);
		txd = 1'b0;
		en = 1'b0;
		idle(4);
		chk("sleep", 32'h18, {mode, rxd, nres, term});
		wk = 1'b0;
		idle(WF + 6);
		wk = 1'b1;
		w(1, POR + 20);
		rng("sleep_por", POR - 8, POR - 2);
		chk("sleep_wake", 32'h1, {mode, rxd, txo, oe});
		finish_test();
	end
endmodule // tb
`default_nettype wire

// [tb/wwdg_host.sv]
// host model driving the two watchdog trigger inputs
`timescale 1ns/100ps
`default_nettype none
module wwdg_host (
	input wire logic clk,
	output logic low_trigger_input,
	output logic high_trigger_input
);
	initial begin
		low_trigger_input = 1'b1;
		high_trigger_input = 1'b0;
	end
	// short len models a glitch on purpose
	task automatic pulse(input bit pol, input int len);
		@(negedge clk);
		if (pol) high_trigger_input = 1'b1;
		else low_trigger_input = 1'b0;
		repeat (len) @(negedge clk);
		high_trigger_input = 1'b0;
		low_trigger_input = 1'b1;
	endtask
endmodule // wwdg_host
`default_nettype wire

// [tb/wwdg_monitor.sv]
// checker on the window watchdog top ports
`timescale 1ns/100ps
`default_nettype none
module wwdg_monitor #(
	parameter integer POR_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mode_enable,
	input wire logic bus_low,
	input wire logic bus_weak_low,
	input wire logic wake_pin,
	input wire logic debug_mode,
	input wire logic vcc_undervoltage,
	input wire logic timebase_resistor_short,
	input wire logic timebase_resistor_open,
	input wire logic reset_out_n_q,
	input wire logic rxd_out_q,
	input wire logic txd_out_q,
	input wire logic txd_oe_q,
	input wire logic [1:0] mode_q
);
	wire calm = !vcc_undervoltage && !timebase_resistor_short && !timebase_resistor_open;
	reg [19:0] low_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 20'h0;
		end else begin
			low_q <= reset_out_n_q ? 20'h0 : low_q + 20'h1;
		end
	end
	// ------
	// properties
	// ------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_uv_reset: assert property (vcc_undervoltage |-> ##[1:4] !reset_out_n_q)
		else $error("reset not low on undervoltage");
	a_reset_len: assert property ($rose(reset_out_n_q) |-> low_q >= POR_CYCLES - 3)
		else $error("reset pulse too short");
	a_debug_off: assert property (debug_mode && reset_out_n_q && calm && mode_q != 2'h3 |=> reset_out_n_q)
		else $error("reset while debug high");
	a_silent_off: assert property (mode_q == 2'h2 && reset_out_n_q && calm |=> reset_out_n_q)
		else $error("reset in silent mode");
	a_oe_normal: assert property (mode_q == 2'h1 && $past(mode_q) == 2'h1 |-> !txd_oe_q)
		else $error("transmit pin driven in normal mode");
	a_prenorm_hold: assert property (mode_q == 2'h0 && !mode_enable |=> mode_q == 2'h0)
		else $error("left pre-normal without enable");
	a_wake_rxd: assert property (mode_q == 2'h2 && calm ##1 mode_q == 2'h0 && calm
		|-> ##[0:2] !rxd_out_q) else $error("receive not low on wake");
	a_remote_src: assert property (mode_q == 2'h2 && bus_low && wake_pin && !bus_weak_low
		##1 mode_q == 2'h0 |-> ##[0:2] txd_oe_q && txd_out_q) else $error("remote source wrong");
	a_en_clears: assert property ($rose(mode_enable) && reset_out_n_q && calm && wake_pin
		&& !bus_low && !bus_weak_low ##1 mode_enable |-> ##[0:2] rxd_out_q && mode_q == 2'h1)
		else $error("enable did not clear wake flags");
endmodule // wwdg_monitor
bind wwdg_top wwdg_monitor #(.POR_CYCLES(POR_CYCLES)) u_mon (.*);
`default_nettype wire

// [verilog/wwdg_filter.v]
// low-level hold filter with one-cycle qualified pulse
`timescale 1ns/100ps
`default_nettype none
module wwdg_filter #(
	parameter integer COUNT = 75,
	parameter integer W = 20
) (
	input wire clk,
	input wire rst_n,
	input wire active_low_in,
	output reg qualified_q
);
	reg [W-1:0] cnt_q;
	reg done_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
			done_q <= 1'b0;
			qualified_q <= 1'b0;
		end else begin
			qualified_q <= 1'b0;
			if (active_low_in) begin
				cnt_q <= {W{1'b0}};
				done_q <= 1'b0;
			end else if (!done_q) begin
				if (cnt_q >= COUNT[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
					done_q <= 1'b1;
					qualified_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // wwdg_filter
`default_nettype wire

// [verilog/wwdg_regs.vh]
// constants for the window watchdog with wake recognition
`ifndef WWDG_REGS_VH
`define WWDG_REGS_VH
`define WWDG_LEAD_PERIODS 3922
`define WWDG_CLOSED_PERIODS 800
`define WWDG_OPEN_PERIODS 840
`define WWDG_NRES_PERIODS 157
`define WWDG_CLK_MHZ 25
`define WWDG_TRIG_MIN_NS 3000
`define WWDG_POR_US 10000
`define WWDG_SHORT_US 4000
`define WWDG_OPEN_US 7000
`define WWDG_OSC_DIV 312
`define WWDG_BUS_FILT 750
`define WWDG_WAKE_FILT 1250
`define WWDG_PH_IDLE 3'h0
`define WWDG_PH_LEAD 3'h1
`define WWDG_PH_CLOSED 3'h2
`define WWDG_PH_OPEN 3'h3
`define WWDG_PH_RESET 3'h4
`define WWDG_PH_POR 3'h5
`define WWDG_MD_PRENORM 2'h0
`define WWDG_MD_NORMAL 2'h1
`define WWDG_MD_SILENT 2'h2
`define WWDG_MD_SLEEP 2'h3
`endif

// [verilog/wwdg_top.v]
// window watchdog with wake-up request and source recognition
`timescale 1ns/100ps
`default_nettype none
`include "wwdg_regs.vh"
module wwdg_top #(
	parameter integer OSC_DIV = `WWDG_OSC_DIV,
	parameter integer POR_CYCLES = `WWDG_POR_US * `WWDG_CLK_MHZ,
	parameter integer SHORT_CYCLES = `WWDG_SHORT_US * `WWDG_CLK_MHZ,
	parameter integer OPEN_CYCLES = `WWDG_OPEN_US * `WWDG_CLK_MHZ,
	parameter integer BUS_FILT = `WWDG_BUS_FILT,
	parameter integer WAKE_FILT = `WWDG_WAKE_FILT
) (
	input wire clk,
	input wire rst_n,
	input wire mode_enable,
	input wire txd_in,
	input wire bus_low,
	input wire bus_weak_low,
	input wire wake_pin,
	input wire low_trigger_input,
	input wire high_trigger_input,
	input wire debug_mode,
	input wire vcc_undervoltage,
	input wire timebase_resistor_short,
	input wire timebase_resistor_open,
	output reg reset_out_n_q,
	output reg rxd_out_q,
	output reg txd_out_q,
	output reg txd_oe_q,
	output reg termination_on_q,
	output reg [1:0] mode_q
);
	// one clock past the limit, so a pulse of exactly 3us stays a glitch
	localparam integer TRIG_CYC = (`WWDG_TRIG_MIN_NS * `WWDG_CLK_MHZ + 999) / 1000 + 1;
	// ---------------------------------------------------------------
	// wake filters
	// ---------------------------------------------------------------
	wire bus_wake;
	wire pin_wake;
	wire weak_wake;
	// filters only run while asleep; bus traffic when awake never wakes
	wire asleep = (mode_q == `WWDG_MD_SILENT) || (mode_q == `WWDG_MD_SLEEP);
	wwdg_filter #(.COUNT(BUS_FILT), .W(20)) u_bus (
		.clk(clk),
		.rst_n(rst_n),
		.active_low_in(~(bus_low & asleep)),
		.qualified_q(bus_wake)
	);
	wwdg_filter #(.COUNT(WAKE_FILT), .W(20)) u_pin (
		.clk(clk),
		.rst_n(rst_n),
		.active_low_in(wake_pin | ~asleep),
		.qualified_q(pin_wake)
	);
	wwdg_filter #(.COUNT(WAKE_FILT), .W(20)) u_weak (
		.clk(clk),
		.rst_n(rst_n),
		.active_low_in(~(bus_weak_low & asleep)),
		.qualified_q(weak_wake)
	);
	// ---------------------------------------------------------------
	// trigger synchronisers and width qualification
	// ---------------------------------------------------------------
	reg low_trigger_input_s1_q, low_trigger_input_s2_q, high_trigger_input_s1_q, high_trigger_input_s2_q;
	reg [7:0] nw_q, pw_q;
	reg trig_evt_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_trigger_input_s1_q <= 1'b1;
			low_trigger_input_s2_q <= 1'b1;
			high_trigger_input_s1_q <= 1'b0;
			high_trigger_input_s2_q <= 1'b0;
			nw_q <= 8'h00;
			pw_q <= 8'h00;
			trig_evt_q <= 1'b0;
		end else begin
			low_trigger_input_s1_q <= low_trigger_input;
			low_trigger_input_s2_q <= low_trigger_input_s1_q;
			high_trigger_input_s1_q <= high_trigger_input;
			high_trigger_input_s2_q <= high_trigger_input_s1_q;
			trig_evt_q <= 1'b0;
			// count active level; fire once when the pulse outlasts the glitch limit
			if (low_trigger_input_s2_q) begin
				nw_q <= 8'h00;
			end else if (nw_q != 8'hFF) begin
				nw_q <= nw_q + 8'h01;
			end
			if (!high_trigger_input_s2_q) begin
				pw_q <= 8'h00;
			end else if (pw_q != 8'hFF) begin
				pw_q <= pw_q + 8'h01;
			end
			if (nw_q == TRIG_CYC[7:0] - 8'h01 && !low_trigger_input_s2_q) begin
				trig_evt_q <= 1'b1;
			end
			if (pw_q == TRIG_CYC[7:0] - 8'h01 && high_trigger_input_s2_q) begin
				trig_evt_q <= 1'b1;
			end
		end
	end
	// ---------------------------------------------------------------
	// oscillator tick
	// ---------------------------------------------------------------
	// free running, so a phase may end up to one tick early
	reg [15:0] div_q;
	reg tick_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (div_q >= OSC_DIV[15:0] - 16'h0001) begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// mode and wake flags
	// ---------------------------------------------------------------
	reg en_d1_q;
	reg wake_req_q;
	reg silent_wake_q;
	wire en_fall = en_d1_q & ~mode_enable;
	// wake beats a same-cycle enable; the enable clears it a cycle later
	wire any_wake = bus_wake | pin_wake | weak_wake;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_d1_q <= 1'b0;
			mode_q <= `WWDG_MD_PRENORM;
			wake_req_q <= 1'b0;
			txd_out_q <= 1'b0;
			txd_oe_q <= 1'b0;
			rxd_out_q <= 1'b1;
			termination_on_q <= 1'b1;
			silent_wake_q <= 1'b0;
		end else begin
			en_d1_q <= mode_enable;
			silent_wake_q <= 1'b0;
			if (vcc_undervoltage) begin
				mode_q <= `WWDG_MD_PRENORM;
				termination_on_q <= 1'b1;
			end else if (any_wake) begin
				mode_q <= `WWDG_MD_PRENORM;
				wake_req_q <= 1'b1;
				txd_out_q <= bus_wake;
				termination_on_q <= 1'b1;
				silent_wake_q <= (mode_q == `WWDG_MD_SILENT);
			end else if (mode_enable) begin
				mode_q <= `WWDG_MD_NORMAL;
				wake_req_q <= 1'b0;
				txd_out_q <= 1'b0;
			end else if (en_fall && mode_q == `WWDG_MD_NORMAL) begin
				mode_q <= txd_in ? `WWDG_MD_SILENT : `WWDG_MD_SLEEP;
				termination_on_q <= 1'b0;
			end
			// source pin driven only while the host still holds enable low
			txd_oe_q <= (mode_q == `WWDG_MD_PRENORM) && !mode_enable;
			// receive stays low through sleep as well
			rxd_out_q <= ~wake_req_q & (mode_q != `WWDG_MD_SLEEP);
		end
	end
	// ---------------------------------------------------------------
	// watchdog phase machine
	// ---------------------------------------------------------------
	reg [2:0] ph_q;
	reg [11:0] pcnt_q;
	reg [23:0] por_q;
	reg [23:0] fault_q;
	reg [7:0] rcnt_q;
	wire wd_off = debug_mode | asleep;
	wire fault_hit = (timebase_resistor_short && fault_q >= SHORT_CYCLES[23:0]) ||
		(timebase_resistor_open && fault_q >= OPEN_CYCLES[23:0]);
	// a broken resistor stops the real oscillator, so faults count plain clocks
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 24'h000000;
		end else if (!(timebase_resistor_short || timebase_resistor_open) || fault_hit) begin
			fault_q <= 24'h000000;
		end else begin
			fault_q <= fault_q + 24'h000001;
		end
	end
	// ---------------------------------------------------------------
	// phase sequencing
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= `WWDG_PH_POR;
			pcnt_q <= 12'h000;
			rcnt_q <= 8'h00;
			por_q <= 24'h000000;
			reset_out_n_q <= 1'b0;
		end else begin
			// pulse length counter only runs inside a watchdog reset
			if (ph_q != `WWDG_PH_RESET) begin
				rcnt_q <= 8'h00;
			end
			// undervoltage outranks every phase; the sequence starts over
			if (vcc_undervoltage || (mode_q == `WWDG_MD_SLEEP && any_wake)) begin
				ph_q <= `WWDG_PH_POR;
				pcnt_q <= 12'h000;
				por_q <= 24'h000000;
				reset_out_n_q <= 1'b0;
			end else if (mode_q == `WWDG_MD_SLEEP) begin
				ph_q <= `WWDG_PH_IDLE;
				pcnt_q <= 12'h000;
				reset_out_n_q <= 1'b0;
			end else if (fault_hit && ph_q != `WWDG_PH_POR && !wd_off) begin
				ph_q <= `WWDG_PH_RESET;
				pcnt_q <= 12'h000;
				rcnt_q <= 8'h00;
				reset_out_n_q <= 1'b0;
			end else begin
				case (ph_q)
					`WWDG_PH_POR: begin
						reset_out_n_q <= 1'b0;
						pcnt_q <= 12'h000;
						if (por_q >= POR_CYCLES[23:0] - 24'h000001) begin
							ph_q <= `WWDG_PH_LEAD;
							pcnt_q <= 12'h000;
							reset_out_n_q <= 1'b1;
						end else begin
							por_q <= por_q + 24'h000001;
						end
					end
					`WWDG_PH_IDLE: begin
						reset_out_n_q <= 1'b1;
						pcnt_q <= 12'h000;
						// a silent wake starts the lead with the receive pin's fall
						if (!wd_off || silent_wake_q) begin
							ph_q <= `WWDG_PH_LEAD;
						end
					end
					`WWDG_PH_RESET: begin
						reset_out_n_q <= 1'b0;
						pcnt_q <= 12'h000;
						if (tick_q) begin
							if (rcnt_q >= `WWDG_NRES_PERIODS - 1) begin
								ph_q <= `WWDG_PH_LEAD;
								reset_out_n_q <= 1'b1;
							end else begin
								rcnt_q <= rcnt_q + 8'h01;
							end
						end
					end
					default: begin
						if (wd_off) begin
							ph_q <= `WWDG_PH_IDLE;
						end else if (trig_evt_q && ph_q == `WWDG_PH_CLOSED) begin
							ph_q <= `WWDG_PH_RESET;
							pcnt_q <= 12'h000;
							reset_out_n_q <= 1'b0;
						end else if (trig_evt_q) begin
							ph_q <= `WWDG_PH_CLOSED;
							pcnt_q <= 12'h000;
						end else if (tick_q) begin
							if ((ph_q == `WWDG_PH_LEAD && pcnt_q >= `WWDG_LEAD_PERIODS - 1) ||
								(ph_q == `WWDG_PH_OPEN && pcnt_q >= `WWDG_OPEN_PERIODS - 1)) begin
								ph_q <= `WWDG_PH_RESET;
								pcnt_q <= 12'h000;
								reset_out_n_q <= 1'b0;
							end else if (ph_q == `WWDG_PH_CLOSED &&
								pcnt_q >= `WWDG_CLOSED_PERIODS - 1) begin
								ph_q <= `WWDG_PH_OPEN;
								pcnt_q <= 12'h000;
							end else begin
								pcnt_q <= pcnt_q + 12'h001;
							end
						end
					end
				endcase
			end
		end
	end
endmodule // wwdg_top
`default_nettype wire
